/* bench/cij_exec_assertions.sv */
// timing checks on the ports of the execution block
// assumes it is bound into cij_exec
`timescale 1ns/1ns
module cij_exec_assertions (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        instrValid,
	input wire logic        fileWrEn_q,
	input wire logic        isNilFlag_q,
	input wire logic        discard_q,
	input wire logic [13:0] instrWord,
	input wire logic [7:0]  fileRdData,
	input wire logic [7:0]  upperLatch,
	input wire logic [7:0]  fileWrData_q,
	input wire logic [7:0]  acc_q,
	input wire logic [12:0] progCounter_q
);
	// a word only counts when it is not being discarded
	wire       tk  = instrValid && !discard_q;
	wire [5:0] op  = instrWord[13:8];
	wire       jmp = tk && instrWord[13:11] == 3'h5;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	jump_pc_a: assert property (jmp |=> progCounter_q ==
		{$past(upperLatch[4:3]), $past(instrWord[10:0])}) else $error("jump target wrong");
	jump_bubble_a: assert property (jmp |=> discard_q) else $error("jump not two cycles");
	or_lit_a: assert property (tk && op == 6'h38 |=>
		acc_q == ($past(acc_q) | $past(instrWord[7:0]))) else $error("or literal wrong");
	inc_wrap_a: assert property (tk && op == 6'h0a && instrWord[7] |=> fileWrEn_q
		&& fileWrData_q == $past(fileRdData) + 8'h01) else $error("increment wrong");
	or_file_a: assert property (tk && op == 6'h04 && !instrWord[7] |=> !fileWrEn_q
		&& acc_q == ($past(acc_q) | $past(fileRdData))) else $error("or file wrong");
	skip_taken_a: assert property (tk && op == 6'h0f && fileRdData == 8'hff |=> discard_q)
		else $error("skip not taken");
	flag_keep_a: assert property (tk && (op == 6'h0f || jmp) |=> $stable(isNilFlag_q))
		else $error("flag changed");
	move_flag_a: assert property (tk && op == 6'h08 |=>
		isNilFlag_q == ($past(fileRdData) == 8'h00)) else $error("move flag wrong");
	one_cycle_a: assert property (tk && op == 6'h0a |=> !discard_q) else $error("extra cycle");
	drop_word_a: assert property (instrValid && discard_q |=> !discard_q && !fileWrEn_q)
		else $error("discarded word acted");
	cover property (jmp);
	cover property (tk && op == 6'h0f && fileRdData == 8'hff);
	cover property (tk && op == 6'h08 && instrWord[7]);
endmodule

/* bench/cij_exec_tb.sv */
// self-checking bench: random words against an integer model
// assumes rtl/ is on the include path
`timescale 1ns/1ns
module cij_exec_tb;
	logic        mclk = 0, reset = 1, instrValid = 0;
	logic [13:0] instrWord = 0;
	logic [7:0]  fileRdData = 0, upperLatch = 0;
	logic [5:0]  ops[5] = '{6'h0a, 6'h0f, 6'h04, 6'h08, 6'h38};
	wire         fileWrEn_q, isNilFlag_q, discard_q;
	wire [6:0]   fileWrAddr_q;
	wire [7:0]   fileWrData_q, acc_q;
	wire [12:0]  progCounter_q;
	int          failures = 0, checked = 0;
	int          acc, z, pc, dsc, dj, we, wa, wd, r, f, res, k, n;
	cij_exec i_cij_exec (
		.mclk          (mclk),
		.reset         (reset),
		.instrValid    (instrValid),
		.instrWord     (instrWord),
		.fileRdData    (fileRdData),
		.upperLatch    (upperLatch),
		.fileWrEn_q    (fileWrEn_q),
		.fileWrAddr_q  (fileWrAddr_q),
		.fileWrData_q  (fileWrData_q),
		.acc_q         (acc_q),
		.isNilFlag_q   (isNilFlag_q),
		.progCounter_q (progCounter_q),
		.discard_q     (discard_q)
	);
	task chk(string nm, logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s exp %0h seen %0h", nm, e, s);
		end
	endtask
	task tally_and_finish;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial forever #25 mclk = ~mclk;
	// ---------------------------------------------
	// main loop: compare, then drive the next word
	// ---------------------------------------------
	initial begin
		n = $urandom(83);
		repeat (12) @(posedge mclk);
		#5 reset = 0;
		for (n = 0; n < 601; n++) begin
			chk("acc", acc_q, acc);
			chk("zero", isNilFlag_q, z);
			chk("pc", progCounter_q, pc);
			chk("skip", discard_q, dsc);
			chk("wen", fileWrEn_q, we);
			chk("wdat", {fileWrAddr_q, fileWrData_q}, wa * 256 + wd);
			// the last pass only checks the answer to the final word
			if (n == 600) break;
			r = $urandom % 7;
			k = $urandom;
			// bias toward ff and 00 so skips and zero results occur often
			f = $urandom % 4 ? $urandom % 256 : 255 * ($urandom % 2);
			instrWord = r < 5 ? {ops[r], k[7:0]} : r == 5 ? {3'h5, k[10:0]} : 14'h0000;
			fileRdData = f;
			upperLatch = k[31:24];
			instrValid = $urandom % 5 != 0;
			we = 0;
			res = -1;
			if (instrValid && dsc) begin
				pc = (pc + !dj) % 8192;
				dsc = 0;
			end else if (instrValid) begin
				pc = (pc + 1) % 8192;
				case (instrWord[13:8])
					6'h0a, 6'h0f: res = (f + 1) % 256;
					6'h04: res = acc | f;
					6'h08: res = f;
					6'h38: begin
						acc = acc | k[7:0];
						z = acc == 0;
					end
				endcase
				if (instrWord[13:11] == 3'h5) begin
					pc = {upperLatch[4:3], k[10:0]};
					dsc = 1;
					dj = 1;
				end
			end
			if (res >= 0) begin
				if (instrWord[13:8] != 6'h0f) z = res == 0;
				else begin
					dsc = res == 0;
					dj = 0;
				end
				if (instrWord[7]) begin
					we = 1;
					wa = instrWord[6:0];
					wd = res;
				end else acc = res;
			end
			@(posedge mclk);
			#5;
		end
		tally_and_finish;
	end
endmodule
bind cij_exec cij_exec_assertions i_cij_exec_assertions (
	.mclk          (mclk),
	.reset         (reset),
	.instrValid    (instrValid),
	.fileWrEn_q    (fileWrEn_q),
	.isNilFlag_q   (isNilFlag_q),
	.discard_q     (discard_q),
	.instrWord     (instrWord),
	.fileRdData    (fileRdData),
	.upperLatch    (upperLatch),
	.fileWrData_q  (fileWrData_q),
	.acc_q         (acc_q),
	.progCounter_q (progCounter_q)
);

/* rtl/cij_exec.v */
// execution of increment, increment-skip, or, move and jump operations
// assumes the fetch stage presents one word per valid cycle together with
// the file register operand already read at the word's 7-bit bank address
`timescale 1ns/1ns
`include "cij_map.vh"

module cij_exec (
	input  wire                      mclk,
	input  wire                      reset,
	input  wire                      instrValid,
	input  wire [`CIJ_INSTR_W-1:0]   instrWord,
	input  wire [`CIJ_DATA_W-1:0]    fileRdData,
	input  wire [`CIJ_DATA_W-1:0]    upperLatch,
	output reg                       fileWrEn_q,
	output reg  [`CIJ_FADDR_W-1:0]   fileWrAddr_q,
	output reg  [`CIJ_DATA_W-1:0]    fileWrData_q,
	output reg  [`CIJ_DATA_W-1:0]    acc_q,
	output reg                       isNilFlag_q,
	output reg  [`CIJ_PC_W-1:0]      progCounter_q,
	output reg                       discard_q
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// byte-op match shared by five decodes
	function isByteOp;
		input [`CIJ_INSTR_W-1:0] w;
		input [5:0]              op;
		begin
			isByteOp = (w[`CIJ_OPF_HI:`CIJ_OPF_LO] == op);
		end
	endfunction

	// operation classes; anything not decoded falls to a plain NOP
	localparam [2:0] OP_NONE     = 3'h0;
	localparam [2:0] OP_INC      = 3'h1;
	localparam [2:0] OP_INC_SKIP = 3'h2;
	localparam [2:0] OP_OR_FILE  = 3'h3;
	localparam [2:0] OP_MOVE     = 3'h4;
	localparam [2:0] OP_OR_LIT   = 3'h5;
	localparam [2:0] OP_JUMP     = 3'h6;

	// flow states: normal issue, shadow of a taken skip, shadow of a jump
	localparam [1:0] FLOW_RUN    = 2'h0;
	localparam [1:0] FLOW_SKIP   = 2'h1;
	localparam [1:0] FLOW_JUMP   = 2'h2;

	reg  [2:0]               opClass;
	reg  [1:0]               flowState_q;
	reg  [1:0]               flowState_d;
	reg  [`CIJ_PC_W-1:0]     pc_d;
	reg  [`CIJ_DATA_W-1:0]   result;
	reg                      writesResult;
	reg                      litToAcc;
	reg                      setsFlag;

	wire                     live       = instrValid & (flowState_q == FLOW_RUN);
	wire                     destFile   = instrWord[`CIJ_DEST_BIT];
	wire [`CIJ_DATA_W-1:0]   incValue   = fileRdData + 8'h01; // wraps modulo 256
	wire [`CIJ_DATA_W-1:0]   orFileVal  = acc_q | fileRdData;
	wire [`CIJ_DATA_W-1:0]   orLitVal   = acc_q | instrWord[`CIJ_LIT_HI:0];
	wire                     skipZero   = (incValue == 8'h00);
	wire [`CIJ_PC_W-1:0]     pcStep     = progCounter_q + 13'h0001;
	wire [`CIJ_PC_W-1:0]     jumpTarget;
	wire                     wrEn_d     = live & writesResult & destFile;
	wire                     accWr      = live & (litToAcc | (writesResult & ~destFile));
	wire                     flagWr     = live & setsFlag;
	wire                     discard_d  = (flowState_d != FLOW_RUN);

	// latch bits on top of the immediate, no carry from the old counter
	assign jumpTarget = {upperLatch[`CIJ_LATCH_HI:`CIJ_LATCH_LO], instrWord[`CIJ_IMM_HI:0]};

	// ------------------------------------------------------------
	// operation class
	// ------------------------------------------------------------
	// byte ops compare the top six bits, the jump only its top three
	always @* begin
		opClass = OP_NONE;
		if (isByteOp(instrWord, `CIJ_OP_INC)) begin
			opClass = OP_INC;
		end else if (isByteOp(instrWord, `CIJ_OP_INC_SKIP)) begin
			opClass = OP_INC_SKIP;
		end else if (isByteOp(instrWord, `CIJ_OP_OR_FILE)) begin
			opClass = OP_OR_FILE;
		end else if (isByteOp(instrWord, `CIJ_OP_MOVE)) begin
			opClass = OP_MOVE;
		end else if (isByteOp(instrWord, `CIJ_OP_OR_LIT)) begin
			opClass = OP_OR_LIT;
		end else if (instrWord[`CIJ_OPF_HI:`CIJ_JOPF_LO] == `CIJ_OP_JUMP) begin
			opClass = OP_JUMP;
		end
	end

	// ------------------------------------------------------------
	// result select
	// ------------------------------------------------------------
	// one adder serves both increments; only the skip variant leaves the flag alone
	always @* begin
		result       = incValue;
		writesResult = 1'b0;
		litToAcc     = 1'b0;
		setsFlag     = 1'b0;
		case (opClass)
			OP_INC: begin
				result       = incValue;
				writesResult = 1'b1;
				setsFlag     = 1'b1;
			end
			OP_INC_SKIP: begin
				result       = incValue;
				writesResult = 1'b1;
			end
			OP_OR_FILE: begin
				result       = orFileVal;
				writesResult = 1'b1;
				setsFlag     = 1'b1;
			end
			OP_MOVE: begin
				result       = fileRdData;
				writesResult = 1'b1;
				setsFlag     = 1'b1;
			end
			OP_OR_LIT: begin
				result       = orLitVal;
				litToAcc     = 1'b1;
				setsFlag     = 1'b1;
			end
			default: begin
				// NOP and jump touch neither accumulator, file nor flag
				result       = incValue;
			end
		endcase
	end

	// ------------------------------------------------------------
	// flow control
	// ------------------------------------------------------------
	// a shadow state waits for the next valid word, however late it comes
	always @* begin
		flowState_d = flowState_q;
		case (flowState_q)
			FLOW_RUN: begin
				if (instrValid & (opClass == OP_JUMP)) begin
					flowState_d = FLOW_JUMP;
				end else if (instrValid & (opClass == OP_INC_SKIP) & skipZero) begin
					flowState_d = FLOW_SKIP;
				end
			end
			FLOW_SKIP, FLOW_JUMP: begin
				if (instrValid) begin
					flowState_d = FLOW_RUN; // shadow word consumed as NOP
				end
			end
			default: begin
				flowState_d = FLOW_RUN;
			end
		endcase
	end

	// a skipped word had an address of its own; the word behind a jump did not
	always @* begin
		pc_d = progCounter_q;
		case (flowState_q)
			FLOW_RUN: begin
				if (instrValid & (opClass == OP_JUMP)) begin
					pc_d = jumpTarget;
				end else if (instrValid) begin
					pc_d = pcStep;
				end
			end
			FLOW_SKIP: begin
				if (instrValid) begin
					pc_d = pcStep;
				end
			end
			FLOW_JUMP: begin
				pc_d = progCounter_q;
			end
			default: begin
				pc_d = progCounter_q;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	// file write strobe is a one-cycle pulse; address and data hold
	always @(posedge mclk) begin
		if (reset) begin
			fileWrEn_q   <= 1'b0;
			fileWrAddr_q <= `CIJ_WADDR_RST;
			fileWrData_q <= `CIJ_WDATA_RST;
		end else begin
			fileWrEn_q <= wrEn_d;
			if (wrEn_d) begin
				fileWrAddr_q <= instrWord[`CIJ_FADDR_W-1:0];
				fileWrData_q <= result;
			end
		end
	end

	// accumulator and zero flag; a flushed word reaches neither
	always @(posedge mclk) begin
		if (reset) begin
			acc_q       <= `CIJ_ACC_RST;
			isNilFlag_q <= `CIJ_FLAG_RST;
		end else begin
			if (accWr) begin
				acc_q <= result;
			end
			if (flagWr) begin
				isNilFlag_q <= (result == 8'h00);
			end
		end
	end

	// counter and flow state move together so discard_q always mirrors the state
	always @(posedge mclk) begin
		if (reset) begin
			progCounter_q <= `CIJ_PC_RST;
			flowState_q   <= FLOW_RUN;
			discard_q     <= 1'b0;
		end else begin
			progCounter_q <= pc_d;
			flowState_q   <= flowState_d;
			discard_q     <= discard_d;
		end
	end

endmodule

/* rtl/cij_map.vh */
// constants for the increment / or / move / jump execution block
// assumes a 14-bit instruction word and an 8-bit data path
`ifndef CIJ_MAP_VH
`define CIJ_MAP_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CIJ_INSTR_W      14
`define CIJ_DATA_W       8
`define CIJ_FADDR_W      7
`define CIJ_PC_W         13

// ----------------------------------------------------------------
// opcode fields: byte-oriented ops match bits 13:8, jump bits 13:11
// ----------------------------------------------------------------
`define CIJ_OP_INC_SKIP  6'h0f
`define CIJ_OP_INC       6'h0a
`define CIJ_OP_OR_FILE   6'h04
`define CIJ_OP_MOVE      6'h08
`define CIJ_OP_OR_LIT    6'h38
`define CIJ_OP_JUMP      3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CIJ_DEST_BIT     7
`define CIJ_LATCH_HI     4
`define CIJ_LATCH_LO     3
`define CIJ_OPF_HI       13
`define CIJ_OPF_LO       8
`define CIJ_JOPF_LO      11
`define CIJ_IMM_HI       10
`define CIJ_LIT_HI       7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIJ_ACC_RST      8'h00
`define CIJ_PC_RST       13'h0000
`define CIJ_WADDR_RST    7'h00
`define CIJ_WDATA_RST    8'h00
`define CIJ_FLAG_RST     1'h0

`endif
